/* File: dv/fhb_hdr_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the framer ports only; bound from the bench top
module fhb_hdr_asserts (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Register bus
  input wire fhb_pkg::fhb_axi_req_s axi_req_i,
  input wire fhb_pkg::fhb_axi_rsp_s axi_rsp_o,
  // Header and receive events
  input wire fhb_pkg::fhb_hdr_s hdr_o,
  input wire logic hdr_valid_o,
  input wire logic rx_hdr_err_o,
  input wire logic ack_needed_o
);
  // Inverted remainder over the 28 covered bits, worked out here on its own
  function automatic logic [4:0] fcs_of(input logic [27:0] d);
    logic [4:0] c;
    logic fb;
    c = 5'h1F;
    for (int k = 27; k >= 0; k--) begin
      fb = c[4] ^ d[k];
      c = {c[3:0], 1'b0} ^ (fb ? 5'h05 : 5'h00);
    end
    return ~c;
  endfunction
  // Expected check field of whatever header is shown
  logic [4:0] fcs_exp;
  assign fcs_exp = fcs_of(hdr_o.bits[39:12]);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  check_field_a: assert property (
    hdr_valid_o |-> {hdr_o.bits[7], hdr_o.bits[11:8]} == fcs_exp)
    else $error("header check field wrong");
  flush_zero_a: assert property (hdr_valid_o |-> hdr_o.bits[6:0] == 7'h00)
    else $error("flush bits not zero");
  sym_count_a: assert property (
    hdr_valid_o |-> hdr_o.symbols == (hdr_o.coherent_bpsk ? 4'hC : 4'hD))
    else $error("header symbol count wrong");
  tone_pilot_a: assert property (
    hdr_valid_o |-> hdr_o.super_robust && hdr_o.default_tones && !hdr_o.pilot_en)
    else $error("header tone or pilot setting wrong");
  ref_sym_a: assert property (
    hdr_valid_o |-> hdr_o.ref_sym_en == (hdr_o.coherent_bpsk && hdr_o.bits[15] && !hdr_o.bits[13]))
    else $error("reference symbol flag wrong");
  dlm_legal_a: assert property (hdr_valid_o |-> hdr_o.bits[14:12] <= 3'h3)
    else $error("reserved delimiter sent");
  ack_resv_a: assert property (
    hdr_valid_o && hdr_o.bits[13] |-> hdr_o.bits[30:24] == 7'h00 && !hdr_o.bits[15])
    else $error("ack reserved bits set");
  data_resv_a: assert property (
    hdr_valid_o && !hdr_o.bits[13] |-> hdr_o.bits[23:22] == 2'h0)
    else $error("data reserved bits set");
  // Header is a one-cycle event and then holds
  hdr_pulse_a: assert property (hdr_valid_o |=> !hdr_valid_o ##1 $stable(hdr_o))
    else $error("header strobe or hold wrong");
  // a bad header never asks for an answer
  rx_excl_a: assert property (rx_hdr_err_o |-> !ack_needed_o)
    else $error("error and ack request together");
  // Write answer stands until taken
  bresp_hold_a: assert property (
    axi_rsp_o.bvalid && !axi_req_i.bready |=> axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp))
    else $error("write response dropped early");
  // Read answer stands until taken
  rdata_hold_a: assert property (
    axi_rsp_o.rvalid && !axi_req_i.rready |=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata))
    else $error("read data dropped early");
endmodule
`default_nettype wire

/* File: dv/fhb_mac_model.sv */
`timescale 1ns/1ps
`default_nettype none
// MAC side: hands header fields over the register bus
module fhb_mac_model (
  // Clock
  input wire logic mclk_i,
  // Register bus
  output var fhb_pkg::fhb_axi_req_s req_o,
  input wire fhb_pkg::fhb_axi_rsp_s rsp_i
);
  // Slow mode holds back ready until the answer shows
  logic slow = 1'b0;
  initial req_o = '0;
  // Write: release each channel when taken; payload scrambled once released
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    req_o.awaddr <= a;
    req_o.awvalid <= 1'b1;
    req_o.wdata <= d;
    req_o.wstrb <= 4'hF;
    req_o.wvalid <= 1'b1;
    req_o.bready <= !slow;
    forever begin
      @(posedge mclk_i);
      if (rsp_i.awready) begin
        req_o.awvalid <= 1'b0;
        req_o.awaddr <= ~a;
      end
      if (rsp_i.wready) begin
        req_o.wvalid <= 1'b0;
        req_o.wdata <= ~d;
      end
      if (req_o.bready && rsp_i.bvalid) begin
        r = rsp_i.bresp;
        req_o.bready <= 1'b0;
        break;
      end
      if (rsp_i.bvalid) req_o.bready <= 1'b1;
    end
  endtask
  // Read: address released when taken, data taken with rready high
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    req_o.araddr <= a;
    req_o.arvalid <= 1'b1;
    req_o.rready <= !slow;
    forever begin
      @(posedge mclk_i);
      if (rsp_i.arready) begin
        req_o.arvalid <= 1'b0;
        req_o.araddr <= ~a;
      end
      if (req_o.rready && rsp_i.rvalid) begin
        d = rsp_i.rdata;
        r = rsp_i.rresp;
        req_o.rready <= 1'b0;
        break;
      end
      if (rsp_i.rvalid) req_o.rready <= 1'b1;
    end
  endtask
endmodule
`default_nettype wire

/* File: dv/tb_frame_header_builder_crc5.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_frame_header_builder_crc5;
  // Clock, reset and design-facing signals
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  fhb_pkg::fhb_axi_req_s axi_req;
  fhb_pkg::fhb_axi_rsp_s axi_rsp;
  fhb_pkg::fhb_hdr_s hdr;
  logic hdr_valid, rx_err, ack_need;
  // Bookkeeping
  int bad_count = 0;
  int comparisons = 0;
  int ack_seen = 0;
  int err_seen = 0;
  int i;
  logic [31:0] rdv, d, t;
  logic [1:0] rs;
  logic [39:0] exp_h;
  logic [5:0] tm;
  logic coh, wd;
  always #25 mclk_i = ~mclk_i;
  fhb_frame_header u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .axi_req_i(axi_req),
    .axi_rsp_o(axi_rsp), .hdr_o(hdr), .hdr_valid_o(hdr_valid), .rx_hdr_err_o(rx_err),
    .ack_needed_o(ack_need));
  fhb_mac_model u_mac (.mclk_i(mclk_i), .req_o(axi_req), .rsp_i(axi_rsp));
  // Receive event pulses are counted as they pass
  always @(posedge mclk_i) begin
    if (ack_need === 1'b1) ack_seen++;
    if (rx_err === 1'b1) err_seen++;
  end
  // Full header from its first 28 bits: inverted remainder, flush zeros
  function automatic logic [39:0] mk(input logic [31:0] h);
    logic [4:0] c;
    logic fb;
    c = 5'h1F;
    for (int k = 31; k >= 4; k--) begin
      fb = c[4] ^ h[k];
      c = {c[3:0], 1'b0} ^ (fb ? 5'h05 : 5'h00);
    end
    c = ~c;
    return {h[31:4], c[3:0], c[4], 7'h00};
  endfunction
  task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Start a transmit, wait for the header strobe, check port and readback
  task automatic hchk(input logic [7:0] c, input logic [8:0] m);
    int n;
    n = 0;
    exp_h = mk(t);
    u_mac.wr(fhb_pkg::OFS_CTRL, {24'h0, c}, rs);
    while (hdr_valid !== 1'b1 && n < 100) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk("hdr_valid", hdr_valid, 1'b1);
    chk("hdr_bits", hdr.bits, exp_h);
    chk("hdr_mode", {hdr.symbols, hdr.super_robust, hdr.coherent_bpsk, hdr.default_tones,
      hdr.pilot_en, hdr.ref_sym_en}, m);
    u_mac.rd(fhb_pkg::OFS_HDR_LO, rdv, rs);
    chk("hdr_lo", rdv, exp_h[39:8]);
    u_mac.rd(fhb_pkg::OFS_HDR_HI, rdv, rs);
    chk("hdr_hi", rdv, {19'h0, m[1], m[0], m[3], m[4], m[2], exp_h[7:0]});
  endtask
  // Hand a received header over and wait until the engine is idle
  task automatic rx(input logic [39:0] h);
    int n;
    n = 0;
    u_mac.wr(fhb_pkg::OFS_STATUS, 32'h0000_001E, rs);
    u_mac.wr(fhb_pkg::OFS_RX_LO, h[39:8], rs);
    u_mac.wr(fhb_pkg::OFS_RX_HI, {24'h0, h[7:0]}, rs);
    u_mac.wr(fhb_pkg::OFS_CTRL, 32'h0000_0002, rs);
    do begin
      u_mac.rd(fhb_pkg::OFS_STATUS, rdv, rs);
      n++;
    end while (rdv[0] !== 1'b0 && n < 50);
  endtask
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    u_mac.rd(fhb_pkg::OFS_CTRL, rdv, rs);
    chk("ctrl_rst", rdv, fhb_pkg::CTRL_RST);
    u_mac.rd(fhb_pkg::OFS_DATA_FLD, rdv, rs);
    chk("fld_rst", rdv, fhb_pkg::FLD_RST);
    // Data frames: every modulation code, variant B, wide with both schemes
    for (i = 0; i < 6; i++) begin
      wd = (i > 3);
      coh = i[1] ^ (i == 5);
      tm = 6'h3F - i[5:0];
      d = {8'h00, i[0], coh, tm, 6'h21 + i[5:0], i[1:0], 8'hA5 ^ i[7:0]};
      // variant B clears upper map bits
      t = {8'hA5 ^ i[7:0], i[1:0], 6'h21 + i[5:0], 2'b00, (i == 3) ? tm & 6'h07 : tm,
        coh, 2'b00, i[0], 4'h0};
      u_mac.wr(fhb_pkg::OFS_DATA_FLD, d, rs);
      hchk(wd ? 8'h11 : (i == 3) ? 8'h05 : 8'h01,
        {wd ? 4'hC : 4'hD, 1'b1, wd, 1'b1, 1'b0, wd & coh});
    end
    // Good header asking for an answer, then a corrupted one
    u_mac.slow = 1'b1;
    rx(mk(32'h1234_1610));
    chk("rx_status_ok", rdv, 32'h0000_0014);
    chk("ack_pulses", ack_seen, 1);
    rx(mk(32'h1234_1610) ^ 40'h00_0010_0000);
    chk("rx_status_bad", rdv, 32'h0000_000C);
    chk("err_pulses", err_seen, 40'h1);
    chk("ack_after_err", ack_seen, 40'h1);
    u_mac.slow = 1'b0;
    // answer the request with positive then negative acknowledgement
    for (i = 0; i < 2; i++) begin
      d = {14'h0, i[0], ~i[0], 8'h5A ^ i[7:0], 8'hC3 ^ i[7:0]};
      t = {8'hC3 ^ i[7:0], ~i[0], 7'h00, 8'h5A ^ i[7:0], 1'b0, 2'b01, i[0], 4'h0};
      u_mac.wr(fhb_pkg::OFS_ACK_FLD, d, rs);
      hchk(8'h09, {4'hD, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0});
    end
    // Unmapped places answer with an error and no data
    u_mac.slow = 1'b1;
    u_mac.rd(8'h20, rdv, rs);
    chk("unmapped_rd", {rs, rdv}, {fhb_pkg::RESP_SLVERR, 32'h0});
    u_mac.wr(8'h24, 32'hFFFF_FFFF, rs);
    chk("unmapped_wr", rs, fhb_pkg::RESP_SLVERR);
    u_mac.slow = 1'b0;
    print_verdict();
  end
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #1_000_000;
    bad_count++;
    print_verdict();
  end
endmodule
bind fhb_frame_header fhb_hdr_asserts u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o), .hdr_o(hdr_o), .hdr_valid_o(hdr_valid_o),
  .rx_hdr_err_o(rx_hdr_err_o), .ack_needed_o(ack_needed_o));
`default_nettype wire

/* File: src/fhb_frame_header.sv */
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module fhb_frame_header (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Register bus
  input wire fhb_pkg::fhb_axi_req_s axi_req_i,
  output fhb_pkg::fhb_axi_rsp_s axi_rsp_o,
  // Modulator side
  output fhb_pkg::fhb_hdr_s hdr_o,
  output logic hdr_valid_o,
  // Receive side events
  output logic rx_hdr_err_o,
  output logic ack_needed_o
);

  // Engine states
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_FINISH} fhb_state_e;
  // One step of the serial check register
  function automatic logic [4:0] crc_step(input logic [4:0] crc, input logic din);
    logic fb;
    fb = crc[4] ^ din;
    crc_step = {crc[3:0], 1'b0} ^ (fb ? fhb_pkg::CRC_POLY : 5'h00);
  endfunction
  // Merge write data under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = res;
  endfunction
  // Register state
  logic [31:0] ctrl_reg; // Mode bits, go bits self clear
  logic [31:0] data_fld_reg; // Data header fields
  logic [31:0] ack_fld_reg; // Acknowledgement fields
  logic [4:0] status_reg; // Sticky event flags
  logic [31:0] rx_lo_reg; // Received header bytes 0-3
  logic [7:0] rx_hi_reg; // Received header byte 4
  // Bus handshake state
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [7:0] waddr_reg; // Address captured with the write
  logic [31:0] wdata_reg; // Data captured with the write
  logic [3:0] wstrb_reg; // Strobes captured with the write
  logic wr_pend_reg; // Write taken, register update next
  logic [7:0] raddr_reg; // Address captured with the read
  logic rd_pend_reg; // Read taken, data next
  // Engine state
  fhb_state_e state_reg;
  logic is_rx_reg; // Current pass checks a received header
  logic [27:0] shift_reg; // Bits still to feed
  logic [27:0] prefix_reg; // Covered bits kept for assembly
  logic [4:0] crc_reg; // Running remainder
  logic [4:0] cnt_reg; // Bits fed so far
  fhb_pkg::fhb_hdr_s hdr_reg;
  logic hdr_valid_reg;
  logic rx_err_reg;
  logic ack_needed_reg;
  // Write side decode
  logic wr_fire, wr_mapped, tx_start, rx_start;
  logic [31:0] wr_mask;
  logic [31:0] ctrl_now; // Control word as it stands once this cycle's write lands
  logic [27:0] tx_prefix;
  logic [5:0] tone_map;
  logic [4:0] evt_set;
  // Events raised by the engine this cycle
  logic fin_tx, fin_rx, rx_bad, rx_wants_ack;
  logic [4:0] rx_field;
  assign wr_fire = wr_pend_reg;
  assign wr_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wr_mapped = (waddr_reg[7:2] <= fhb_pkg::OFS_RX_HI[7:2]) && (waddr_reg[1:0] == 2'h0);
  // Go bits are pulses; the engine ignores them while busy
  assign tx_start = wr_fire && (waddr_reg == fhb_pkg::OFS_CTRL) && wstrb_reg[0]
                    && wdata_reg[fhb_pkg::CTRL_TX_GO] && (state_reg == ST_IDLE);
  assign rx_start = wr_fire && (waddr_reg == fhb_pkg::OFS_CTRL) && wstrb_reg[0]
                    && wdata_reg[fhb_pkg::CTRL_RX_GO] && !wdata_reg[fhb_pkg::CTRL_TX_GO]
                    && (state_reg == ST_IDLE);
  // Mode bits written with the go bit must shape this very header, not the next one
  assign ctrl_now = (wr_fire && (waddr_reg == fhb_pkg::OFS_CTRL))
                    ? merge(ctrl_reg, wdata_reg, wstrb_reg) : ctrl_reg;
  // Build the 28 covered header bits from the field registers
  always_comb begin
    // One map bit per six-tone group, bit 0 lowest band
    tone_map = data_fld_reg[21:16];
    // Upper groups fall outside variant B spectrum
    if (ctrl_now[fhb_pkg::CTRL_VARIANT_B]) begin
      tone_map[5:3] = 3'h0;
    end
    if (ctrl_now[fhb_pkg::CTRL_IS_ACK]) begin
      // Check low, more-segments flag, check high
      // Only positive or negative codes can leave
      tx_prefix = {ack_fld_reg[7:0], ack_fld_reg[16], 7'h00, ack_fld_reg[15:8], 1'b0,
                   (ack_fld_reg[17] ? fhb_pkg::DLM_NEG_ACK : fhb_pkg::DLM_POS_ACK)};
    end else begin
      // Phase detect count in byte 0
      // Modulation type in byte 1 top bits
      // Length field counts symbols divided by four
      // Map sits in byte 2 low bits, reserved bits zero
      // Delimiter restricted to the two legal data codes
      tx_prefix = {data_fld_reg[7:0], data_fld_reg[9:8], data_fld_reg[15:10], 2'h0, tone_map,
                   data_fld_reg[22],
                   (data_fld_reg[23] ? fhb_pkg::DLM_ACK_REQ : fhb_pkg::DLM_NO_ACK)};
    end
  end
  // Engine completion decode
  assign fin_tx = (state_reg == ST_FINISH) && !is_rx_reg;
  assign fin_rx = (state_reg == ST_FINISH) && is_rx_reg;
  assign rx_field = {rx_hi_reg[7], rx_lo_reg[3:0]};
  // Receiver compares inverted remainder with the field
  assign rx_bad = (rx_field != ~crc_reg);
  // Data header with delimiter one needs an answer
  assign rx_wants_ack = !rx_bad && (rx_lo_reg[6:4] == fhb_pkg::DLM_ACK_REQ);
  assign evt_set = {fin_rx && rx_wants_ack, fin_rx && rx_bad, fin_rx, fin_tx, 1'b0};
  // Write address and data are taken together, once both are offered
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      // Accept only while no response or update is outstanding
      if (axi_req_i.awvalid && axi_req_i.wvalid && !awready_reg && !wr_pend_reg
          && !bvalid_reg) begin
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
        wr_pend_reg <= 1'b1;
        waddr_reg <= axi_req_i.awaddr;
        wdata_reg <= axi_req_i.wdata;
        wstrb_reg <= axi_req_i.wstrb;
      end
    end
  end
  // Write response, one per write, held until bready
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= fhb_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? fhb_pkg::RESP_OKAY : fhb_pkg::RESP_SLVERR;
    end else if (bvalid_reg && axi_req_i.bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  // Software-written registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= fhb_pkg::CTRL_RST;
      data_fld_reg <= fhb_pkg::FLD_RST;
      ack_fld_reg <= fhb_pkg::FLD_RST;
      rx_lo_reg <= fhb_pkg::FLD_RST;
      rx_hi_reg <= 8'h00;
    end else if (wr_fire) begin
      unique case (waddr_reg)
        fhb_pkg::OFS_CTRL: begin
          // Go bits never stay stored; they act only as pulses
          ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000_001C;
        end
        fhb_pkg::OFS_DATA_FLD: begin
          data_fld_reg <= merge(data_fld_reg, wdata_reg, wstrb_reg) & 32'h00FF_FFFF;
        end
        fhb_pkg::OFS_ACK_FLD: begin
          ack_fld_reg <= merge(ack_fld_reg, wdata_reg, wstrb_reg) & 32'h0003_FFFF;
        end
        fhb_pkg::OFS_RX_LO: begin
          rx_lo_reg <= merge(rx_lo_reg, wdata_reg, wstrb_reg);
        end
        fhb_pkg::OFS_RX_HI: begin
          if (wstrb_reg[0]) begin
            rx_hi_reg <= wdata_reg[7:0];
          end
        end
        default: begin
          // Status is cleared elsewhere; read-only or unmapped, nothing stored
        end
      endcase
    end
  end
  // Sticky event flags, cleared by writing one; a new event wins
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      status_reg <= 5'h00;
    end else begin
      if (wr_fire && (waddr_reg == fhb_pkg::OFS_STATUS) && wstrb_reg[0]) begin
        status_reg <= (status_reg & ~(wdata_reg[4:0] & wr_mask[4:0])) | evt_set;
      end else begin
        status_reg <= status_reg | evt_set;
      end
    end
  end
  // Read channel, one read at a time
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      arready_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      raddr_reg <= 8'h00;
    end else begin
      arready_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      if (axi_req_i.arvalid && !arready_reg && !rd_pend_reg && !rvalid_reg) begin
        arready_reg <= 1'b1;
        rd_pend_reg <= 1'b1;
        raddr_reg <= axi_req_i.araddr;
      end
    end
  end
  // Read data mux; busy bit reflects live engine state, the other status bits the sticky flags
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= fhb_pkg::RESP_OKAY;
    end else if (rd_pend_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= fhb_pkg::RESP_OKAY;
      unique case (raddr_reg)
        fhb_pkg::OFS_CTRL: rdata_reg <= ctrl_reg;
        fhb_pkg::OFS_DATA_FLD: rdata_reg <= data_fld_reg;
        fhb_pkg::OFS_ACK_FLD: rdata_reg <= ack_fld_reg;
        fhb_pkg::OFS_STATUS: rdata_reg <= {27'h0, status_reg[4:1], state_reg != ST_IDLE};
        fhb_pkg::OFS_HDR_LO: rdata_reg <= hdr_reg.bits[39:8];
        fhb_pkg::OFS_HDR_HI: rdata_reg <= {16'h0, 3'h0, hdr_reg.pilot_en, hdr_reg.ref_sym_en,
                                           hdr_reg.coherent_bpsk, hdr_reg.super_robust,
                                           hdr_reg.default_tones, hdr_reg.bits[7:0]};
        fhb_pkg::OFS_RX_LO: rdata_reg <= rx_lo_reg;
        fhb_pkg::OFS_RX_HI: rdata_reg <= {24'h0, rx_hi_reg};
        default: begin
          // Unmapped address answers zero with an error
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= fhb_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && axi_req_i.rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  // Serial check engine, shared by transmit and receive
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      is_rx_reg <= 1'b0;
      shift_reg <= 28'h000_0000;
      prefix_reg <= 28'h000_0000;
      crc_reg <= fhb_pkg::CRC_INIT;
      cnt_reg <= 5'h00;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          // Transmit wins when both go bits are written together
          if (tx_start || rx_start) begin
            is_rx_reg <= rx_start;
            shift_reg <= rx_start ? rx_lo_reg[31:4] : tx_prefix;
            prefix_reg <= rx_start ? rx_lo_reg[31:4] : tx_prefix;
            crc_reg <= fhb_pkg::CRC_INIT;
            cnt_reg <= 5'h00;
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          // One bit a cycle, byte 0 MSB first
          crc_reg <= crc_step(crc_reg, shift_reg[27]);
          shift_reg <= {shift_reg[26:0], 1'b0};
          cnt_reg <= cnt_reg + 5'h01;
          // Stop after the 28 covered bits
          if (cnt_reg == fhb_pkg::CNT_LAST) begin
            state_reg <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE; // Unused code recovers to idle
      endcase
    end
  end
  // Assemble the header and symbol settings for the modulator
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      hdr_reg <= '0;
      hdr_valid_reg <= 1'b0;
    end else begin
      hdr_valid_reg <= fin_tx;
      if (fin_tx) begin
        // Low four check bits in byte 3, MSB in byte 4 bit 7
        // Six zero flush bits follow, byte 4 bit 0 zero too
        hdr_reg.bits <= {prefix_reg, ~crc_reg[3:0], ~crc_reg[4], 7'h00};
        // Narrow bandplans use thirteen header symbols
        // Wide bandplan uses twelve coherent binary symbols
        hdr_reg.symbols <= ctrl_reg[fhb_pkg::CTRL_WIDE] ? fhb_pkg::SYM_WIDE
                                                       : fhb_pkg::SYM_NARROW;
        hdr_reg.super_robust <= 1'b1;
        hdr_reg.coherent_bpsk <= ctrl_reg[fhb_pkg::CTRL_WIDE];
        // Header always on every unmasked carrier
        hdr_reg.default_tones <= 1'b1;
        // Wide header carries no pilots; narrow needs none here
        hdr_reg.pilot_en <= 1'b0;
        // Wide differential payload drops the reference symbols
        hdr_reg.ref_sym_en <= ctrl_reg[fhb_pkg::CTRL_WIDE] && data_fld_reg[22]
                              && !ctrl_reg[fhb_pkg::CTRL_IS_ACK];
      end
    end
  end
  // Receive outcome pulses toward the MAC
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rx_err_reg <= 1'b0;
      ack_needed_reg <= 1'b0;
    end else begin
      rx_err_reg <= fin_rx && rx_bad;
      // Tell the MAC an acknowledgement header is owed
      ack_needed_reg <= fin_rx && rx_wants_ack;
    end
  end
  // Outputs straight from flops
  assign axi_rsp_o = '{awready: awready_reg, wready: wready_reg, bvalid: bvalid_reg,
                       bresp: bresp_reg, arready: arready_reg, rvalid: rvalid_reg,
                       rdata: rdata_reg, rresp: rresp_reg};
  assign hdr_o = hdr_reg;
  assign hdr_valid_o = hdr_valid_reg;
  assign rx_hdr_err_o = rx_err_reg;
  assign ack_needed_o = ack_needed_reg;

endmodule
`default_nettype wire

/* File: src/fhb_pkg.sv */
package fhb_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DATA_FLD = 8'h04;
  localparam logic [7:0] OFS_ACK_FLD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_HDR_LO = 8'h10;
  localparam logic [7:0] OFS_HDR_HI = 8'h14;
  localparam logic [7:0] OFS_RX_LO = 8'h18;
  localparam logic [7:0] OFS_RX_HI = 8'h1C;

  // Control register bit positions
  localparam int CTRL_TX_GO = 0;
  localparam int CTRL_RX_GO = 1;
  localparam int CTRL_VARIANT_B = 2;
  localparam int CTRL_IS_ACK = 3;
  localparam int CTRL_WIDE = 4;

  // Status register bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_TX_DONE = 1;
  localparam int ST_RX_DONE = 2;
  localparam int ST_RX_ERR = 3;
  localparam int ST_ACK_REQ = 4;

  // Values after reset
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] FLD_RST = 32'h0000_0000;

  // Header geometry and check polynomial
  localparam int HDR_BITS = 40;
  localparam int CRC_BITS = 28;
  localparam logic [4:0] CRC_INIT = 5'h1F;
  localparam logic [4:0] CRC_POLY = 5'h05;
  localparam logic [3:0] SYM_NARROW = 4'hD;
  localparam logic [3:0] SYM_WIDE = 4'hC;
  localparam logic [4:0] CNT_LAST = 5'h1B;

  // Delimiter codes
  localparam logic [2:0] DLM_NO_ACK = 3'h0;
  localparam logic [2:0] DLM_ACK_REQ = 3'h1;
  localparam logic [2:0] DLM_POS_ACK = 3'h2;
  localparam logic [2:0] DLM_NEG_ACK = 3'h3;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Master to slave
  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } fhb_axi_req_s;

  // Slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fhb_axi_rsp_s;

  // Header handed to the modulator with its symbol settings
  typedef struct packed {
    logic [39:0] bits;
    logic [3:0] symbols;
    logic super_robust;
    logic coherent_bpsk;
    logic default_tones;
    logic pilot_en;
    logic ref_sym_en;
  } fhb_hdr_s;

endpackage
